// [hw/dtzq_ctrl.sv]
// dtzq_ctrl: controller end, issues commands and drives odt under zq and odt timing
//
// Functional notes
// [R1] channel quiet during any zq window
// [R2] zq only with banks closed, trp met
// [R3] no calibration started by self-refresh exit
// [R4] zq no earlier than txs after srx
// [R5] shared resistor: zq windows never overlap
// [R6] cke held high through calibration
// [R7] odt low during calibration
// [R8] calibration current off once done
// [R9] self refresh: termination off, pin ignored
// [R10] enable and strength from mr1/mr2 fields
// [R11] both fields zero: termination off
// [R12] termination follows odt pin only
// [R13] synchronous timing whenever dll locked
// [R14] dll off: odt held low
// [R15] on/off after odtlon/odtloff cycles
// [R16] odt latency is cwl plus al minus two
// [R17] odt high at least odth4 after rise
// [R18] after write with odt: odth4/odth8 hold
// [R19] odt dropped before read data
// [R20] no termination before read postamble ends
// [R21] zq may overlap dll relock after srx
// [R22] first zqcl long window, then oper/short
// [R23] odth8 is six cycles
// [R24] odth4 is four cycles
`timescale 1ns/100ps
`default_nettype none
module dtzq_ctrl (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr, // register byte offset
  input wire logic [31:0] i_wdata,
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // valid the cycle after i_rd
  dtzq_link_if.ctrl link
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] mr0_r, mr1_r, mr2_r; // shadows of what was written
  logic sr_r, pd_r, bank_r, first_r, refused_r, odt_req_r;
  logic [9:0] zq_cnt_r, trp_cnt_r, txs_cnt_r;
  logic [5:0] rdw_cnt_r; // read turnaround left
  logic [2:0] hold_r, hold_nxt; // odt high time left
  logic odt_r, odt_nxt, cke_r;
  dtzq_pkg::dtzq_cmd_t cmd_r;
  logic [2:0] ba_r;
  logic [15:0] addr_r;
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic cmd_wr, odt_wr, stat_wr, legal, is_zq, zq_busy, zq_ready, state_ok, issue;
  logic rd_ok, force_low, rd_issue, wr_issue, raise_ok, rise;
  logic [3:0] code;
  logic [4:0] odtl;
  logic [5:0] rl6;
  logic [2:0] dec, c_rise, c_wr;
  dtzq_pkg::dtzq_cmd_t ccmd;

  assign cmd_wr = i_wr && (i_addr == dtzq_pkg::REG_CMD);
  assign odt_wr = i_wr && (i_addr == dtzq_pkg::REG_ODT);
  assign stat_wr = i_wr && (i_addr == dtzq_pkg::REG_STAT);
  assign code = i_wdata[3:0];
  assign legal = (code <= dtzq_pkg::CMD_LAST);
  assign ccmd = legal ? dtzq_pkg::dtzq_cmd_t'(code) : dtzq_pkg::cmd_nop;
  assign is_zq = (ccmd == dtzq_pkg::cmd_zqcl) || (ccmd == dtzq_pkg::cmd_zqcs);
  assign zq_busy = (zq_cnt_r != 10'h0);
  assign odtl = dtzq_pkg::odtl_f(mr0_r, mr1_r, mr2_r); // [R16]
  assign rl6 = {1'h0, dtzq_pkg::rl_f(mr0_r, mr1_r)};
  // banks closed, trp and txs run out, cke high, odt already low
  assign zq_ready = !bank_r && (trp_cnt_r == 10'h0) && (txs_cnt_r == 10'h0) && !sr_r && !pd_r
    && !odt_r; // [R2] [R4] [R6] [R7]
  // in sr or pd only the matching exit is taken
  assign state_ok = !(sr_r || pd_r) || (sr_r && (ccmd == dtzq_pkg::cmd_srx))
    || (pd_r && (ccmd == dtzq_pkg::cmd_pdx));
  // a read needs odt droppable at issue so rtt is off before data
  assign rd_ok = (ccmd != dtzq_pkg::cmd_rd) || !odt_r || (hold_r == 3'h0); // [R19]
  // one zq window at a time also serialises a shared resistor
  assign issue = cmd_wr && legal && !zq_busy && state_ok && rd_ok && (!is_zq || zq_ready); // [R1] [R5]
  assign rd_issue = issue && (ccmd == dtzq_pkg::cmd_rd);
  assign wr_issue = issue && ((ccmd == dtzq_pkg::cmd_wr8) || (ccmd == dtzq_pkg::cmd_wr4));

  // ----------------------------------------------------------------
  // odt pin and its hold counter
  // ----------------------------------------------------------------
  // zq window keeps the pin low; dll off mode and self refresh keep it low once any running hold has ended
  assign force_low = zq_busy || (issue && is_zq) || mr1_r[dtzq_pkg::MR1_DLL_OFF] || sr_r; // [R7] [R14]
  // raise only when its turn-on lands after the read postamble
  assign raise_ok = odt_req_r && !force_low && ({1'h0, odtl} >= rdw_cnt_r); // [R20]
  assign odt_nxt = odt_r ? ((hold_r != 3'h0) || (odt_req_r && !force_low && !rd_issue))
    : (raise_ok && !rd_issue); // [R17] [R18] [R19]
  assign rise = !odt_r && odt_nxt;
  assign dec = (hold_r != 3'h0) ? hold_r - 3'h1 : 3'h0;
  assign c_rise = rise ? dtzq_pkg::ODTH4_CYC - 3'h1 : 3'h0; // [R17] [R24]
  // write registered with odt high restarts the minimum
  assign c_wr = !(wr_issue && odt_nxt) ? 3'h0 : (ccmd == dtzq_pkg::cmd_wr8)
    ? dtzq_pkg::ODTH8_CYC - 3'h1 : dtzq_pkg::ODTH4_CYC - 3'h1; // [R18] [R23] [R24]

  // both minimums must hold, so keep the largest
  always_comb begin
    hold_nxt = dec;
    if (c_rise > hold_nxt) begin
      hold_nxt = c_rise;
    end
    if (c_wr > hold_nxt) begin
      hold_nxt = c_wr;
    end
  end

  // ----------------------------------------------------------------
  // link drive: one command cycle, then nop
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_r <= dtzq_pkg::cmd_nop;
      ba_r <= 3'h0;
      addr_r <= 16'h0;
      odt_r <= 1'h0;
      hold_r <= 3'h0;
    end else begin
      cmd_r <= issue ? ccmd : dtzq_pkg::cmd_nop; // [R1]
      if (issue) begin
        ba_r <= i_wdata[dtzq_pkg::CMD_BA_LSB +: 3];
        addr_r <= i_wdata[dtzq_pkg::CMD_ADDR_LSB +: 16];
      end
      odt_r <= odt_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power states and cke; srx does not imply a calibration
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sr_r <= 1'h0;
      pd_r <= 1'h0;
      cke_r <= 1'h1;
    end else if (issue) begin
      if ((ccmd == dtzq_pkg::cmd_sre) || (ccmd == dtzq_pkg::cmd_pde)) begin
        cke_r <= 1'h0; // refused during zq, so cke stays high there
      end else if ((ccmd == dtzq_pkg::cmd_srx) || (ccmd == dtzq_pkg::cmd_pdx)) begin
        cke_r <= 1'h1;
      end
      if (ccmd == dtzq_pkg::cmd_sre) begin
        sr_r <= 1'h1;
      end else if (ccmd == dtzq_pkg::cmd_srx) begin
        sr_r <= 1'h0;
      end
      if (ccmd == dtzq_pkg::cmd_pde) begin
        pd_r <= 1'h1;
      end else if (ccmd == dtzq_pkg::cmd_pdx) begin
        pd_r <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // timers; zq, trp and txs loaded with n-1 so the next legal edge is n later
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      zq_cnt_r <= 10'h0;
      trp_cnt_r <= 10'h0;
      txs_cnt_r <= 10'h0;
      rdw_cnt_r <= 6'h0;
      first_r <= 1'h1;
      bank_r <= 1'h0;
    end else begin
      zq_cnt_r <= zq_busy ? zq_cnt_r - 10'h1 : 10'h0;
      trp_cnt_r <= (trp_cnt_r != 10'h0) ? trp_cnt_r - 10'h1 : 10'h0;
      txs_cnt_r <= (txs_cnt_r != 10'h0) ? txs_cnt_r - 10'h1 : 10'h0;
      rdw_cnt_r <= (rdw_cnt_r != 6'h0) ? rdw_cnt_r - 6'h1 : 6'h0;
      if (issue && (ccmd == dtzq_pkg::cmd_zqcs)) begin
        zq_cnt_r <= dtzq_pkg::ZQCS_CYC - 10'h1; // [R22]
      end else if (issue && (ccmd == dtzq_pkg::cmd_zqcl)) begin
        zq_cnt_r <= (first_r ? dtzq_pkg::ZQINIT_CYC : dtzq_pkg::ZQOPER_CYC) - 10'h1; // [R22]
        first_r <= 1'h0;
      end
      if (issue && ((ccmd == dtzq_pkg::cmd_pre) || (ccmd == dtzq_pkg::cmd_prea))) begin
        trp_cnt_r <= dtzq_pkg::TRP_CYC - 10'h1; // [R2]
        bank_r <= 1'h0;
      end else if (issue && (ccmd == dtzq_pkg::cmd_act)) begin
        bank_r <= 1'h1;
      end
      // zq may follow txs without waiting for dll lock
      if (issue && (ccmd == dtzq_pkg::cmd_srx)) begin
        txs_cnt_r <= dtzq_pkg::TXS_CYC - 10'h1; // [R4] [R21]
      end
      if (rd_issue) begin
        rdw_cnt_r <= rl6 + dtzq_pkg::BURST_CYC + dtzq_pkg::POST_CYC; // [R20]
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers; a refusal sets a sticky flag, set beats clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mr0_r <= 16'h0;
      mr1_r <= 16'h0;
      mr2_r <= 16'h0;
      odt_req_r <= 1'h0;
      refused_r <= 1'h0;
    end else begin
      if (issue && (ccmd == dtzq_pkg::cmd_mrs)) begin
        if (i_wdata[dtzq_pkg::CMD_BA_LSB +: 3] == 3'h0) begin
          mr0_r <= i_wdata[dtzq_pkg::CMD_ADDR_LSB +: 16];
        end
        if (i_wdata[dtzq_pkg::CMD_BA_LSB +: 3] == 3'h1) begin
          mr1_r <= i_wdata[dtzq_pkg::CMD_ADDR_LSB +: 16];
        end
        if (i_wdata[dtzq_pkg::CMD_BA_LSB +: 3] == 3'h2) begin
          mr2_r <= i_wdata[dtzq_pkg::CMD_ADDR_LSB +: 16];
        end
      end
      if (odt_wr) begin
        odt_req_r <= i_wdata[0];
      end
      if (cmd_wr && !issue) begin
        refused_r <= 1'h1;
      end else if (stat_wr && i_wdata[dtzq_pkg::ST_REFUSED]) begin
        refused_r <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, present only in the cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] stat_word, rd_mux;
  always_comb begin
    stat_word = 32'h0;
    stat_word[dtzq_pkg::ST_ZQ] = zq_busy;
    stat_word[dtzq_pkg::ST_ODT] = odt_r;
    stat_word[dtzq_pkg::ST_REFUSED] = refused_r;
    stat_word[dtzq_pkg::ST_SR] = sr_r;
    stat_word[dtzq_pkg::ST_PD] = pd_r;
    stat_word[dtzq_pkg::ST_BANK] = bank_r;
    stat_word[dtzq_pkg::ST_HOLD] = (hold_r != 3'h0);
    stat_word[dtzq_pkg::ST_FIRST] = first_r;
  end
  assign rd_mux = (i_addr == dtzq_pkg::REG_STAT) ? stat_word
    : (i_addr == dtzq_pkg::REG_ODT) ? {31'h0, odt_req_r}
    : (i_addr == dtzq_pkg::REG_CMD) ? {16'h0, 12'h0, cmd_r} : 32'h0;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= i_rd ? rd_mux : 32'h0;
    end
  end

  assign o_rdata = rdata_r;
  assign link.cmd = cmd_r;
  assign link.ba = ba_r;
  assign link.addr = addr_r;
  assign link.cke = cke_r;
  assign link.odt = odt_r;
endmodule
`default_nettype wire

// [hw/dtzq_pkg.sv]
// dtzq_pkg: shared command set, timing counts, register map and latency decoders
package dtzq_pkg;

  // ----------------------------------------------------------------
  // command set on the memory link
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    cmd_nop, cmd_act, cmd_pre, cmd_prea, cmd_ref, cmd_rd, cmd_wr8, cmd_wr4,
    cmd_mrs, cmd_zqcl, cmd_zqcs, cmd_sre, cmd_srx, cmd_pde, cmd_pdx
  } dtzq_cmd_t;
  localparam logic [3:0] CMD_LAST = 4'he; // highest legal code

  // ----------------------------------------------------------------
  // timing, in clock cycles at 250 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PS = 4000;
  localparam int TRP_NS = 14; // precharge period
  localparam int TXS_NS = 170; // self-refresh exit to zq
  localparam logic [9:0] TRP_CYC = 10'((TRP_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [9:0] TXS_CYC = 10'((TXS_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [9:0] ZQINIT_CYC = 10'h200; // first long calibration
  localparam logic [9:0] ZQOPER_CYC = 10'h100; // later long calibration
  localparam logic [9:0] ZQCS_CYC = 10'h040; // short calibration
  localparam logic [2:0] ODTH4_CYC = 3'h4;
  localparam logic [2:0] ODTH8_CYC = 3'h6;
  localparam logic [5:0] BURST_CYC = 6'h4; // bl8 data on the bus
  localparam logic [5:0] POST_CYC = 6'h1; // postamble guard

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int MR0_DLL_PD = 12; // 1: dll kept on in precharge pd
  localparam int MR1_DLL_OFF = 0; // 1: dll off mode

  // ----------------------------------------------------------------
  // controller register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ODT = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CMD_BA_LSB = 4; // bank/mr select [6:4]
  localparam int CMD_ADDR_LSB = 16; // address [31:16]
  localparam int ST_ZQ = 0;
  localparam int ST_ODT = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SR = 3;
  localparam int ST_PD = 4;
  localparam int ST_BANK = 5;
  localparam int ST_HOLD = 6;
  localparam int ST_FIRST = 7;

  // ----------------------------------------------------------------
  // latency decoders, used by both ends
  // ----------------------------------------------------------------
  function automatic logic [4:0] cl_f(input logic [15:0] mr0);
    return {2'h0, mr0[6:4]} + 5'h4;
  endfunction

  function automatic logic [4:0] al_f(input logic [15:0] mr0, input logic [15:0] mr1);
    logic [4:0] al;
    al = 5'h0;
    if (mr1[4:3] == 2'h1) begin
      al = cl_f(mr0) - 5'h1;
    end else if (mr1[4:3] == 2'h2) begin
      al = cl_f(mr0) - 5'h2;
    end
    return al;
  endfunction

  // turn-on and turn-off latency: cwl + al - 2
  function automatic logic [4:0] odtl_f(input logic [15:0] mr0, input logic [15:0] mr1,
                                        input logic [15:0] mr2);
    return {2'h0, mr2[5:3]} + 5'h5 + al_f(mr0, mr1) - 5'h2;
  endfunction

  // read latency: al + cl
  function automatic logic [4:0] rl_f(input logic [15:0] mr0, input logic [15:0] mr1);
    return al_f(mr0, mr1) + cl_f(mr0);
  endfunction

endpackage

// [hw/dtzq_link_if.sv]
// dtzq_link_if: command, cke and odt wires between controller and dram
`timescale 1ns/100ps
`default_nettype none
interface dtzq_link_if;
  dtzq_pkg::dtzq_cmd_t cmd; // one command per clock
  logic [2:0] ba; // mode register select for mrs
  logic [15:0] addr; // mode register value for mrs
  logic cke; // clock enable
  logic odt; // termination request pin
  modport ctrl (output cmd, ba, addr, cke, odt);
  modport dram (input cmd, ba, addr, cke, odt);
endinterface
`default_nettype wire

// [hw/dtzq_dly.sv]
// dtzq_dly: delay line with a run-time selected tap
`timescale 1ns/100ps
`default_nettype none
module dtzq_dly #(
  parameter int DEPTH = 32,
  parameter int LW = 5
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_d,
  input wire logic [LW-1:0] i_lat,
  output logic o_q
);
  logic [DEPTH-1:0] sh_r; // sh_r[k] holds the input taken k+1 edges ago

  // ----------------------------------------------------------------
  // shift
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[DEPTH-2:0], i_d};
    end
  end

  // tap lat-1; the caller's output flop adds the last cycle
  assign o_q = (i_lat == '0) ? i_d : sh_r[i_lat - LW'(1)];
endmodule
`default_nettype wire

// [hw/dtzq_dram.sv]
// dtzq_dram: dram end, zq calibration engine and synchronous termination
`timescale 1ns/100ps
`default_nettype none
module dtzq_dram (
  input wire logic i_clk,
  input wire logic i_nrst,
  dtzq_link_if.dram link,
  output logic o_rtt_on, // termination switched on
  output logic [2:0] o_rtt_nom_code, // nominal strength code
  output logic [1:0] o_rtt_wr_code, // write strength code
  output logic o_zq_cal, // calibration current path on
  output logic o_sync_mode, // synchronous odt timing active
  output logic o_self_refresh, // in self refresh
  output logic o_dq_drive // read data being driven
);
  logic [15:0] mr0_r, mr1_r, mr2_r; // mode registers
  logic sr_r, pd_r; // self refresh, power down
  logic first_r; // no long calibration since reset
  logic [9:0] zq_cnt_r, zq_cnt_nxt; // calibration window left
  logic [5:0] rd_cnt_r, rd_cnt_nxt; // cycles to end of read postamble
  logic rtt_on_r, zq_on_r, sync_r, drv_r;
  logic [4:0] odtl;
  logic [5:0] rl6;
  logic odt_en, sync, odt_in, odt_tap, rd_win, drv_win, zq_go, rtt_nxt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign odtl = dtzq_pkg::odtl_f(mr0_r, mr1_r, mr2_r); // [R16]
  assign rl6 = {1'h0, dtzq_pkg::rl_f(mr0_r, mr1_r)};
  // enabled if any nominal or write strength bit set
  assign odt_en = (o_rtt_nom_code != 3'h0) || (o_rtt_wr_code != 2'h0); // [R10] [R11]
  // dll on and locked; slow precharge power down freezes it
  assign sync = !mr1_r[dtzq_pkg::MR1_DLL_OFF] && !sr_r && !(pd_r && !mr0_r[dtzq_pkg::MR0_DLL_PD]); // [R13]
  assign odt_in = link.odt && !sr_r; // [R9]
  // only an explicit command starts calibration, never srx
  assign zq_go = ((link.cmd == dtzq_pkg::cmd_zqcl) || (link.cmd == dtzq_pkg::cmd_zqcs)) && !sr_r
    && (zq_cnt_r == 10'h0); // [R3]
  assign rd_win = (rd_cnt_r != 6'h0) && (rd_cnt_r <= dtzq_pkg::BURST_CYC + dtzq_pkg::POST_CYC);
  assign drv_win = (rd_cnt_r > dtzq_pkg::POST_CYC) && (rd_cnt_r <= dtzq_pkg::BURST_CYC + dtzq_pkg::POST_CYC);
  // pin decides, write decode never enters; off through read burst and postamble and from sre on
  assign rtt_nxt = odt_tap && odt_en && sync && !sr_r && !rd_win
    && (link.cmd != dtzq_pkg::cmd_sre); // [R9] [R12] [R20]

  // ----------------------------------------------------------------
  // odt pin delayed by odtl
  // ----------------------------------------------------------------
  dtzq_dly #(.DEPTH(32), .LW(5)) u_dly (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(odt_in),
    .i_lat(odtl), // [R15]
    .o_q(odt_tap)
  );

  // ----------------------------------------------------------------
  // counters, next values
  // ----------------------------------------------------------------
  always_comb begin
    zq_cnt_nxt = (zq_cnt_r != 10'h0) ? zq_cnt_r - 10'h1 : 10'h0;
    if (zq_go) begin
      if (link.cmd == dtzq_pkg::cmd_zqcs) begin
        zq_cnt_nxt = dtzq_pkg::ZQCS_CYC; // [R22]
      end else begin
        zq_cnt_nxt = first_r ? dtzq_pkg::ZQINIT_CYC : dtzq_pkg::ZQOPER_CYC; // [R22]
      end
    end
    rd_cnt_nxt = (rd_cnt_r != 6'h0) ? rd_cnt_r - 6'h1 : 6'h0;
    if (link.cmd == dtzq_pkg::cmd_rd) begin
      rd_cnt_nxt = rl6 + dtzq_pkg::BURST_CYC + dtzq_pkg::POST_CYC;
    end
  end

  // ----------------------------------------------------------------
  // mode registers and power states
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mr0_r <= 16'h0;
      mr1_r <= 16'h0;
      mr2_r <= 16'h0;
      sr_r <= 1'h0;
      pd_r <= 1'h0;
      first_r <= 1'h1;
    end else begin
      if (link.cmd == dtzq_pkg::cmd_mrs) begin
        if (link.ba == 3'h0) begin
          mr0_r <= link.addr;
        end
        if (link.ba == 3'h1) begin
          mr1_r <= link.addr;
        end
        if (link.ba == 3'h2) begin
          mr2_r <= link.addr;
        end
      end
      if (link.cmd == dtzq_pkg::cmd_sre) begin
        sr_r <= 1'h1;
      end else if (link.cmd == dtzq_pkg::cmd_srx) begin
        sr_r <= 1'h0;
      end
      if (link.cmd == dtzq_pkg::cmd_pde) begin
        pd_r <= 1'h1;
      end else if (link.cmd == dtzq_pkg::cmd_pdx) begin
        pd_r <= 1'h0;
      end
      if (zq_go && (link.cmd == dtzq_pkg::cmd_zqcl)) begin
        first_r <= 1'h0; // [R22]
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration, read window and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      zq_cnt_r <= 10'h0;
      rd_cnt_r <= 6'h0;
      zq_on_r <= 1'h0;
      rtt_on_r <= 1'h0;
      sync_r <= 1'h0;
      drv_r <= 1'h0;
    end else begin
      zq_cnt_r <= zq_cnt_nxt;
      rd_cnt_r <= rd_cnt_nxt;
      zq_on_r <= (zq_cnt_nxt != 10'h0); // [R8]
      rtt_on_r <= rtt_nxt;
      sync_r <= sync;
      drv_r <= drv_win;
    end
  end

  assign o_rtt_on = rtt_on_r;
  assign o_rtt_nom_code = {mr1_r[9], mr1_r[6], mr1_r[2]}; // [R10]
  assign o_rtt_wr_code = mr2_r[10:9]; // [R10]
  assign o_zq_cal = zq_on_r;
  assign o_sync_mode = sync_r;
  assign o_self_refresh = sr_r;
  assign o_dq_drive = drv_r;
endmodule
`default_nettype wire

// [sim/dtzq_asserts.sv]
// dtzq_asserts: timing checks on the link joining controller and dram
`timescale 1ns/100ps
`default_nettype none
module dtzq_asserts (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire dtzq_pkg::dtzq_cmd_t i_cmd,
  input wire logic i_cke,
  input wire logic i_odt,
  input wire logic i_rtt_on,
  input wire logic i_zq_cal,
  input wire logic i_self_refresh,
  input wire logic i_dq_drive
);
  // ----------------------------------------------------------------
  // one clock domain, so clock and reset are given once
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire zq_c = (i_cmd == dtzq_pkg::cmd_zqcl) || (i_cmd == dtzq_pkg::cmd_zqcs); // any calibration
  chk_zq_quiet: assert property (zq_c |=> (i_cmd == dtzq_pkg::cmd_nop) [*8])
    else $error("command during zq window");
  chk_zq_start: assert property ($rose(i_zq_cal) |-> $past(zq_c))
    else $error("calibration without zq command");
  chk_zq_len: assert property (i_cmd == dtzq_pkg::cmd_zqcs |=> i_zq_cal [*8] ##56 i_zq_cal ##1 !i_zq_cal)
    else $error("short window length wrong");
  chk_zq_cke: assert property (i_zq_cal |-> i_cke)
    else $error("cke low in calibration");
  chk_zq_odt: assert property (i_zq_cal |-> !i_odt && !i_rtt_on)
    else $error("termination in calibration");
  chk_sr_rtt: assert property (i_self_refresh |-> !i_rtt_on)
    else $error("termination in self refresh");
  chk_odt_hold: assert property ($rose(i_odt) |-> i_odt [*4])
    else $error("odt high too short");
  chk_wr8_hold: assert property (i_cmd == dtzq_pkg::cmd_wr8 && i_odt |-> i_odt [*6])
    else $error("odt dropped after write");
  chk_rd_odt: assert property (i_cmd == dtzq_pkg::cmd_rd |-> !i_odt)
    else $error("odt high at read");
  chk_rd_rtt: assert property (i_dq_drive |-> !i_rtt_on)
    else $error("termination while driving");
endmodule
`default_nettype wire

// [sim/dram_termination_and_zq_control_test.sv]
// dram_termination_and_zq_control_test: register-driven bench for both ends
`timescale 1ns/100ps
`default_nettype none
module dram_termination_and_zq_control_test;
  logic i_clk = 1'b0, i_nrst = 1'b0, wr = 1'b0, rd = 1'b0; // clock, reset, strobes
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d; // d holds the last read
  logic rtt, zq, sync, sr, dq;
  logic [2:0] nom;
  logic [1:0] wrc;
  logic [15:0] m0, m1, m2; // random mode register images
  int bad_count = 0, tests_run = 0, cyc = 0, seed = 28, zlen = 0, n, i, k, odtl;
  dtzq_link_if link ();
  dtzq_ctrl dtzq_ctrl_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .link(link));
  dtzq_dram dtzq_dram_inst (.i_clk(i_clk), .i_nrst(i_nrst), .link(link), .o_rtt_on(rtt), .o_rtt_nom_code(nom),
    .o_rtt_wr_code(wrc), .o_zq_cal(zq), .o_sync_mode(sync), .o_self_refresh(sr), .o_dq_drive(dq));
  dtzq_asserts dtzq_asserts_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_cmd(link.cmd), .i_cke(link.cke),
    .i_odt(link.odt), .i_rtt_on(rtt), .i_zq_cal(zq), .i_self_refresh(sr), .i_dq_drive(dq));
  always #2 i_clk = ~i_clk;
  // cycle ceiling and length counter for calibration and read bursts
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (zq === 1'b1 || dq === 1'b1) zlen <= zlen + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] v);
    wreg(dtzq_pkg::REG_CMD, {v, 9'h0, b, c});
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  // odt latency worked out independently: cwl + al - 2
  function automatic int exp_odtl(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    int al;
    al = (b[4:3] == 2'h1) ? a[6:4] + 3 : (b[4:3] == 2'h2) ? a[6:4] + 2 : 0;
    return c[5:3] + 5 + al - 2;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    idle(10);
    i_nrst <= 1'b1;
    rreg(dtzq_pkg::REG_STAT);
    check(32'(d[dtzq_pkg::ST_FIRST]), 32'h1);
    wreg(dtzq_pkg::REG_ODT, 32'h1);
    idle(30);
    check(32'(rtt), 32'h0);
    wreg(dtzq_pkg::REG_ODT, 32'h0);
    idle(20);
    $display("test reset and disabled termination done");
    // long, long again, short; a command inside each window is refused
    for (k = 0; k < 3; k++) begin
      zlen = 0;
      issue((k < 2) ? 4'h9 : 4'ha, 3'h0, 16'h0);
      issue(4'h1, 3'h0, 16'h0);
      rreg(dtzq_pkg::REG_STAT);
      check(32'(d[dtzq_pkg::ST_REFUSED]), 32'h1);
      wreg(dtzq_pkg::REG_STAT, 32'h4);
      idle(600);
      check(32'(zlen), {22'h0, (k == 0) ? dtzq_pkg::ZQINIT_CYC : (k == 1) ? dtzq_pkg::ZQOPER_CYC :
        dtzq_pkg::ZQCS_CYC});
    end
    $display("test zq windows done");
    // random latencies and strengths
    for (k = 0; k < 3; k++) begin
      i = $random(seed);
      m0 = {9'h0, 3'(i[2:0]), 4'h0};
      m1 = {6'h0, i[5], 4'h0, 2'(i[4:3] % 3), 1'b1, 2'h0};
      m2 = {5'h0, i[9:8], 4'h0, i[7:6], 3'h0};
      issue(4'h8, 3'h0, m0);
      issue(4'h8, 3'h1, m1);
      issue(4'h8, 3'h2, m2);
      odtl = exp_odtl(m0, m1, m2);
      idle(4);
      check(32'(nom), {29'h0, m1[9], m1[6], m1[2]});
      check(32'(wrc), 32'(m2[10:9]));
      wreg(dtzq_pkg::REG_ODT, 32'h1);
      #1 n = 0;
      while (link.odt !== 1'b1 && n < 9) begin
        @(posedge i_clk);
        #1 n++;
      end
      n = 0;
      while (rtt !== 1'b1 && n < 40) begin
        @(posedge i_clk);
        #1 n++;
      end
      check(32'(n), 32'(odtl + 1));
      check(32'(sync), 32'h1);
      idle(8);
      wreg(dtzq_pkg::REG_ODT, 32'h0);
      idle(30);
      check(32'(rtt), 32'h0);
    end
    $display("test odt latency done");
    // write with odt high, then an early drop request, then a read
    issue(4'h1, 3'h0, 16'h0);
    wreg(dtzq_pkg::REG_ODT, 32'h1);
    issue(4'h6, 3'h0, 16'h0);
    wreg(dtzq_pkg::REG_ODT, 32'h0);
    idle(20);
    // read with odt requested: pin drops for it, termination returns after
    wreg(dtzq_pkg::REG_ODT, 32'h1);
    idle(10);
    zlen = 0;
    issue(4'h5, 3'h0, 16'h0);
    idle(40);
    check(32'(zlen), 32'(dtzq_pkg::BURST_CYC));
    check(32'(rtt), 32'h1);
    issue(4'h2, 3'h0, 16'h0);
    idle(10);
    $display("test write and read turnaround done");
    // self refresh entered with termination on; srx alone starts nothing; zq waits for txs
    issue(4'hb, 3'h0, 16'h0);
    idle(30);
    check(32'(sr), 32'h1);
    check(32'(rtt), 32'h0);
    wreg(dtzq_pkg::REG_ODT, 32'h0);
    issue(4'hc, 3'h0, 16'h0);
    issue(4'ha, 3'h0, 16'h0);
    rreg(dtzq_pkg::REG_STAT);
    check(32'(d[dtzq_pkg::ST_REFUSED]), 32'h1);
    check(32'(zq), 32'h0);
    wreg(dtzq_pkg::REG_STAT, 32'h4);
    idle(50);
    issue(4'ha, 3'h0, 16'h0);
    rreg(dtzq_pkg::REG_STAT);
    check(32'(d[dtzq_pkg::ST_REFUSED]), 32'h0);
    idle(80);
    $display("test self refresh done");
    report_and_stop();
  end
endmodule
`default_nettype wire
